//--- hw/oam_decoder.sv
/*
 * operand addressing decoder with its small cpu register file.
 * takes instruction bytes one per valid strobe, works out where
 * operands come from and where the result goes, reads the memory
 * or register space through a one-cycle read port, and issues the
 * write. assumes memory read data returns one cycle after the
 * read strobe, and that the opcode class bits come from an outer
 * opcode table on the same clock.
 */
`timescale 1ns/1ps
`include "oam_defines.svh"

// Summary of operation
// - source direct: read op1 address into acc/idx
// - arithmetic second source is the destination register
// - source indexed: read op1+index into acc/idx
// - direct/indexed modes are two bytes long
// - destination direct: write op1, arithmetic reads it
// - memory destination leaves accumulator unchanged
// - destination indexed: source is accumulator only
// - indexed arithmetic reads then writes same location
// - dest direct immediate: op1 address, op2 data
// - dest indexed immediate: op1+index address, op2 data
// - immediate destination modes are three bytes long
// - memory-to-memory only for move, three bytes
// - memory-to-memory never reaches register space
// - register-space opcode routes address to registers
// - and-immediate on flags writes flags back
// - source immediate: op1 to named register, two bytes
// - flags bank bit picks register-space bank
module oam_decoder #(
  parameter int DW = 8  // data and address width
) (
  input  wire logic                CLOCK,
  input  wire logic                RESET,
  input  wire logic                BYTE_VALID,   // instruction byte strobe
  input  wire logic [DW-1:0]       BYTE_DATA,    // instruction byte
  input  wire oam_pkg::oam_mode_e  MODE,         // mode, with opcode byte
  input  wire oam_pkg::oam_reg_e   REG_SEL,      // register named in opcode
  input  wire logic                IS_ARITH,     // two-source operation
  input  wire logic                IS_MOVE,      // plain move
  input  wire logic                IS_AND,       // logical and
  input  wire logic                TO_REGSPACE,  // opcode names register space
  input  wire logic [DW-1:0]       MEM_RDATA,    // read data, next cycle
  output logic                     BYTE_READY,   // decoder takes a byte
  output logic [1:0]               INSTR_LEN,    // decoded length in bytes
  output logic                     MEM_RD,       // read strobe
  output logic                     MEM_WR,       // write strobe
  output logic [DW-1:0]            MEM_ADDR,     // operand address
  output logic [DW-1:0]            MEM_WDATA,    // write data
  output logic                     MEM_REGSPACE, // 1 register space, 0 ram
  output logic                     MEM_BANK,     // register-space bank
  output logic                     ILLEGAL,      // mode not allowed
  output logic [DW-1:0]            ACC,          // accumulator
  output logic [DW-1:0]            IDX,          // index register
  output logic [DW-1:0]            FLAGS,        // flags register
  output logic [DW-1:0]            STACK_POINTER // stack pointer
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    oam_pkg::oam_state_e st;      // fetch sequencer
    oam_pkg::oam_mode_e  mode;    // latched mode
    oam_pkg::oam_reg_e   rsel;    // latched register
    logic                arith;   // latched class bits
    logic                move;
    logic                andop;
    logic                regsp;
    logic [1:0]          len;     // decoded length
    logic [DW-1:0]       op1;     // first operand byte
    logic [DW-1:0]       op2;     // second operand byte
    logic [1:0]          phase;   // exec step
    logic                rd;      // output strobes
    logic                wr;
    logic [DW-1:0]       addr;
    logic [DW-1:0]       wdata;
    logic                rspace;
    logic                illegal;
    logic [DW-1:0]       acc;     // cpu registers
    logic [DW-1:0]       idx;
    logic [DW-1:0]       flags;
    logic [DW-1:0]       sp;
  } oam_state_s;

  oam_state_s cur;       // registered state
  oam_state_s next_cur;  // next value

  // helpers for the current instruction
  logic [DW-1:0] idx_addr;   // indexed address
  logic [DW-1:0] reg_val;    // value of named register
  logic [DW-1:0] alu_res;    // operation result

  // ****************************************************************
  // address and operand helpers
  // ****************************************************************
  always_comb begin
    // carry deliberately lost: wraps within the 256-byte space
    idx_addr = DW'(cur.op1 + cur.idx);
    unique case (cur.rsel)
      oam_pkg::OAM_REG_ACC:   reg_val = cur.acc;
      oam_pkg::OAM_REG_IDX:   reg_val = cur.idx;
      oam_pkg::OAM_REG_FLAGS: reg_val = cur.flags;
      oam_pkg::OAM_REG_SP:    reg_val = cur.sp;
      default:                reg_val = cur.acc;  // illegal code
    endcase
  end

  // ****************************************************************
  // sequencer and register file
  // ****************************************************************
  always_comb begin
    logic [DW-1:0] src;   // first source
    logic [DW-1:0] other; // second source
    src      = '0;
    other    = '0;
    alu_res  = '0;
    next_cur = cur;
    next_cur.rd = 1'b0;
    next_cur.wr = 1'b0;
    unique case (cur.st)
      oam_pkg::OAM_ST_OPCODE: begin
        if (BYTE_VALID) begin
          next_cur.mode    = MODE;
          next_cur.rsel    = REG_SEL;
          next_cur.arith   = IS_ARITH;
          next_cur.move    = IS_MOVE;
          next_cur.andop   = IS_AND;
          next_cur.regsp   = TO_REGSPACE;
          next_cur.illegal = 1'b0;
          next_cur.phase   = 2'h0;
          unique case (MODE)
            oam_pkg::OAM_MODE_NONE: next_cur.len = `OAM_LEN_ONE;
            oam_pkg::OAM_MODE_SRC_IMM,
            oam_pkg::OAM_MODE_SRC_DIR,
            oam_pkg::OAM_MODE_SRC_IDX,
            oam_pkg::OAM_MODE_DST_DIR,
            oam_pkg::OAM_MODE_DST_IDX:
              next_cur.len = `OAM_LEN_TWO;
            default: next_cur.len = `OAM_LEN_THREE;
          endcase
          // memory-to-memory is legal only for a move
          if (MODE == oam_pkg::OAM_MODE_MEM_MEM && !IS_MOVE) begin
            next_cur.illegal = 1'b1;
          end
          // indexed destination accepts only the accumulator
          if (MODE == oam_pkg::OAM_MODE_DST_IDX
              && REG_SEL != oam_pkg::OAM_REG_ACC) begin
            next_cur.illegal = 1'b1;
          end
          next_cur.st = (MODE == oam_pkg::OAM_MODE_NONE) ?
                        oam_pkg::OAM_ST_OPCODE : oam_pkg::OAM_ST_OPND1;
        end
      end
      oam_pkg::OAM_ST_OPND1: begin
        if (BYTE_VALID) begin
          next_cur.op1 = BYTE_DATA;
          next_cur.st  = (cur.len == `OAM_LEN_THREE) ?
                         oam_pkg::OAM_ST_OPND2 : oam_pkg::OAM_ST_EXEC;
        end
      end
      oam_pkg::OAM_ST_OPND2: begin
        if (BYTE_VALID) begin
          next_cur.op2 = BYTE_DATA;
          next_cur.st  = oam_pkg::OAM_ST_EXEC;
        end
      end
      oam_pkg::OAM_ST_EXEC: begin
        // illegal instructions are dropped with no access
        if (cur.illegal) begin
          next_cur.st = oam_pkg::OAM_ST_OPCODE;
        end else begin
          unique case (cur.mode)
            oam_pkg::OAM_MODE_SRC_IMM: begin
              src = cur.op1;
              other = reg_val;
              if (cur.andop) begin
                alu_res = src & other;
              end else if (cur.arith) begin
                alu_res = DW'(src + other);
              end else begin
                alu_res = src;
              end
              unique case (cur.rsel)
                oam_pkg::OAM_REG_ACC:   next_cur.acc = alu_res;
                oam_pkg::OAM_REG_IDX:   next_cur.idx = alu_res;
                oam_pkg::OAM_REG_FLAGS: next_cur.flags = alu_res;
                oam_pkg::OAM_REG_SP:    next_cur.sp = alu_res;
                default:                next_cur.acc = alu_res;
              endcase
              next_cur.st = oam_pkg::OAM_ST_OPCODE;
            end
            oam_pkg::OAM_MODE_SRC_DIR,
            oam_pkg::OAM_MODE_SRC_IDX: begin
              if (cur.phase == 2'h0) begin
                next_cur.rd     = 1'b1;
                next_cur.addr   = (cur.mode == oam_pkg::OAM_MODE_SRC_IDX) ?
                                  idx_addr : cur.op1;
                next_cur.rspace = cur.regsp;
                next_cur.phase  = 2'h1;
              end else if (cur.phase == 2'h1) begin
                next_cur.phase = 2'h2;  // read data lands next cycle
              end else begin
                src = MEM_RDATA;
                other = reg_val;
                alu_res = cur.arith ? DW'(src + other) :
                          (cur.andop ? (src & other) : src);
                if (cur.rsel == oam_pkg::OAM_REG_IDX) begin
                  next_cur.idx = alu_res;
                end else begin
                  next_cur.acc = alu_res;
                end
                next_cur.st = oam_pkg::OAM_ST_OPCODE;
              end
            end
            default: begin
              // memory destination modes; acc only read here
              if (cur.phase == 2'h0) begin
                next_cur.addr = (cur.mode == oam_pkg::OAM_MODE_DST_IDX ||
                                 cur.mode == oam_pkg::OAM_MODE_DST_IDX_IMM) ?
                                idx_addr : cur.op1;
                // mem-to-mem stays in ram
                next_cur.rspace = (cur.mode == oam_pkg::OAM_MODE_MEM_MEM) ?
                                  1'b0 : cur.regsp;
                if (cur.mode == oam_pkg::OAM_MODE_MEM_MEM) begin
                  next_cur.addr = cur.op2;
                  next_cur.rd = 1'b1;
                end else begin
                  next_cur.rd = cur.arith | cur.andop;
                end
                next_cur.phase = 2'h1;
              end else if (cur.phase == 2'h1) begin
                next_cur.phase = 2'h2;
              end else begin
                if (cur.mode == oam_pkg::OAM_MODE_DST_DIR_IMM ||
                    cur.mode == oam_pkg::OAM_MODE_DST_IDX_IMM) begin
                  src = cur.op2;
                end else if (cur.mode == oam_pkg::OAM_MODE_MEM_MEM) begin
                  src = MEM_RDATA;
                end else begin
                  src = reg_val;
                end
                other = MEM_RDATA;
                alu_res = (cur.mode == oam_pkg::OAM_MODE_MEM_MEM) ? src :
                          cur.arith ? DW'(src + other) :
                          (cur.andop ? (src & other) : src);
                next_cur.wr    = 1'b1;
                next_cur.wdata = alu_res;
                if (cur.mode == oam_pkg::OAM_MODE_MEM_MEM) begin
                  next_cur.addr = cur.op1;
                end
                // same address as the read for indexed arithmetic
                next_cur.st = oam_pkg::OAM_ST_OPCODE;
              end
            end
          endcase
        end
      end
      default: next_cur.st = oam_pkg::OAM_ST_OPCODE;  // illegal code
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      cur         <= '0;
      cur.st      <= oam_pkg::OAM_ST_OPCODE;
      cur.mode    <= oam_pkg::OAM_MODE_NONE;
      cur.rsel    <= oam_pkg::OAM_REG_ACC;
      cur.acc     <= `OAM_ACC_RESET;
      cur.idx     <= `OAM_IDX_RESET;
      cur.flags   <= `OAM_FLAGS_RESET;
      cur.sp      <= `OAM_SP_RESET;
      cur.len     <= `OAM_LEN_ONE;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign BYTE_READY    = (cur.st != oam_pkg::OAM_ST_EXEC);
  assign INSTR_LEN     = cur.len;
  assign MEM_RD        = cur.rd;
  assign MEM_WR        = cur.wr;
  assign MEM_ADDR      = cur.addr;
  assign MEM_WDATA     = cur.wdata;
  assign MEM_REGSPACE  = cur.rspace;
  assign MEM_BANK      = cur.flags[`OAM_FLAG_BANK_BIT];
  assign ILLEGAL       = cur.illegal;
  assign ACC           = cur.acc;
  assign IDX           = cur.idx;
  assign FLAGS         = cur.flags;
  assign STACK_POINTER = cur.sp;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_len_two: assert property (@(posedge CLOCK) disable iff (RESET)
    (cur.st == oam_pkg::OAM_ST_OPND1 && (cur.mode == oam_pkg::OAM_MODE_SRC_DIR
     || cur.mode == oam_pkg::OAM_MODE_DST_IDX)) |-> cur.len == 2'h2)
    else $error("direct or indexed mode not two bytes");
  a_len_three: assert property (@(posedge CLOCK) disable iff (RESET)
    (cur.st == oam_pkg::OAM_ST_OPND2) |-> cur.len == 2'h3)
    else $error("second operand fetched for short instruction");
  a_memmem_ram: assert property (@(posedge CLOCK) disable iff (RESET)
    (cur.mode == oam_pkg::OAM_MODE_MEM_MEM && (cur.rd || cur.wr)) |-> !cur.rspace)
    else $error("memory-to-memory reached register space");
  a_acc_kept: assert property (@(posedge CLOCK) disable iff (RESET)
    cur.wr |-> $stable(cur.acc))
    else $error("accumulator changed on memory write");
  a_idx_same: assert property (@(posedge CLOCK) disable iff (RESET)
    (cur.rd && cur.mode == oam_pkg::OAM_MODE_DST_IDX) |-> ##2 (cur.wr &&
     cur.addr == $past(cur.addr, 2)))
    else $error("indexed write not at read address");
  a_src_addr: assert property (@(posedge CLOCK) disable iff (RESET)
    (cur.rd && cur.mode == oam_pkg::OAM_MODE_SRC_IDX) |->
     cur.addr == DW'(cur.op1 + cur.idx))
    else $error("source indexed address wrong");
  a_bank_bit: assert property (@(posedge CLOCK) disable iff (RESET)
    MEM_BANK == FLAGS[4])
    else $error("bank select not from flags bit");
  a_dst_idx_acc: assert property (@(posedge CLOCK) disable iff (RESET)
    (cur.wr && cur.mode == oam_pkg::OAM_MODE_DST_IDX) |-> cur.rsel == oam_pkg::OAM_REG_ACC)
    else $error("indexed destination from non-accumulator");
  a_illegal_quiet: assert property (@(posedge CLOCK) disable iff (RESET)
    cur.illegal |-> !(cur.wr || cur.rd))
    else $error("illegal instruction wrote memory");

  c_memmem: cover property (@(posedge CLOCK) cur.wr && cur.mode == oam_pkg::OAM_MODE_MEM_MEM);
  c_flags_and: cover property (@(posedge CLOCK) $changed(cur.flags));
  c_src_idx: cover property (@(posedge CLOCK) cur.rd && cur.mode == oam_pkg::OAM_MODE_SRC_IDX);

endmodule

//--- shared/oam_defines.svh
/*
 * timing-free constants for the operand addressing decoder:
 * instruction lengths, flag bit positions and reset values.
 * assumes inclusion by bare name from design files.
 */
`ifndef OAM_DEFINES_SVH
`define OAM_DEFINES_SVH

// ****************************************************************
// instruction lengths in bytes
// ****************************************************************
`define OAM_LEN_ONE    2'h1
`define OAM_LEN_TWO    2'h2
`define OAM_LEN_THREE  2'h3

// ****************************************************************
// flags register fields and register reset values
// ****************************************************************
`define OAM_FLAG_BANK_BIT  4
`define OAM_FLAGS_RESET    8'h02
`define OAM_ACC_RESET      8'h00
`define OAM_IDX_RESET      8'h00
`define OAM_SP_RESET       8'h00

`endif

//--- shared/oam_pkg.sv
/*
 * types for the operand addressing decoder: addressing modes,
 * register targets and fetch sequencer states.
 * assumes nothing beyond a systemverilog compiler.
 */
package oam_pkg;

  // ****************************************************************
  // addressing modes, one-hot
  // ****************************************************************
  typedef enum logic [8:0] {
    OAM_MODE_SRC_IMM     = 9'h001,  // result to reg, operand 1 immediate
    OAM_MODE_SRC_DIR     = 9'h002,  // source at operand 1
    OAM_MODE_SRC_IDX     = 9'h004,  // source at operand 1 + index
    OAM_MODE_DST_DIR     = 9'h008,  // result to operand 1
    OAM_MODE_DST_IDX     = 9'h010,  // result to operand 1 + index
    OAM_MODE_DST_DIR_IMM = 9'h020,  // result to op1, source op2 immediate
    OAM_MODE_DST_IDX_IMM = 9'h040,  // result to op1+index, op2 immediate
    OAM_MODE_MEM_MEM     = 9'h080,  // move ram op2 to ram op1
    OAM_MODE_NONE        = 9'h100   // single-byte, no operand
  } oam_mode_e;

  // ****************************************************************
  // cpu register selector
  // ****************************************************************
  typedef enum logic [3:0] {
    OAM_REG_ACC   = 4'h1,
    OAM_REG_IDX   = 4'h2,
    OAM_REG_FLAGS = 4'h4,
    OAM_REG_SP    = 4'h8
  } oam_reg_e;

  // ****************************************************************
  // operand fetch sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    OAM_ST_OPCODE = 4'h1,
    OAM_ST_OPND1  = 4'h2,
    OAM_ST_OPND2  = 4'h4,
    OAM_ST_EXEC   = 4'h8
  } oam_state_e;

endpackage

//--- testbench/oam_testbench.sv
/*
 * self-checking bench for the operand addressing decoder: feeds
 * instruction bytes, stands in for data ram and register space.
 * assumes the decoder package and defines are compiled first.
 */
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin \
  num_errors++; $display("BAD %0t %s", $time, msg); end end

module testbench;
  // ****************************************************************
  // signals and memory stand-in
  // ****************************************************************
  logic               clock;       // 10 MHz core clock
  logic               reset;       // sync, active high
  logic               byte_valid;  // byte strobe to decoder
  logic [7:0]         byte_data;   // instruction byte
  oam_pkg::oam_mode_e mode;        // opcode class: mode
  oam_pkg::oam_reg_e  reg_sel;     // opcode class: register
  logic               is_arith, is_move, is_and, to_regspace;
  logic [7:0]         mem_rdata;   // read data back to decoder
  logic               byte_ready, mem_rd, mem_wr, mem_regspace, mem_bank, illegal;
  logic [1:0]         instr_len;
  logic [7:0]         mem_addr, mem_wdata, acc, idx, flags, stack_pointer;
  logic [7:0]         mem [0:1023];  // ram, then two register banks
  logic               rd_hold;       // read data still presented
  logic [7:0]         rd_addr, wr_addr, wr_data;  // last accesses seen
  logic               rd_rs, wr_rs;
  int                 rd_n, wr_n, cyc, num_errors, cmp_count;

  oam_decoder #(.DW(8)) DUT (.CLOCK(clock), .RESET(reset), .BYTE_VALID(byte_valid),
    .BYTE_DATA(byte_data), .MODE(mode), .REG_SEL(reg_sel), .IS_ARITH(is_arith),
    .IS_MOVE(is_move), .IS_AND(is_and), .TO_REGSPACE(to_regspace),
    .MEM_RDATA(mem_rdata), .BYTE_READY(byte_ready), .INSTR_LEN(instr_len),
    .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .MEM_REGSPACE(mem_regspace), .MEM_BANK(mem_bank), .ILLEGAL(illegal), .ACC(acc),
    .IDX(idx), .FLAGS(flags), .STACK_POINTER(stack_pointer));

  // clock: 100 ns period
  always #50 clock = ~clock;

  // flat slot: ram low, register banks above it
  function automatic logic [9:0] slot(logic rs, logic bk, logic [7:0] a);
    return rs ? {1'b1, bk, a} : {2'b00, a};
  endfunction

  // read data held two cycles, then scrambled so stale data never matches
  always @(negedge clock) begin
    if (mem_rd) begin
      mem_rdata <= mem[slot(mem_regspace, mem_bank, mem_addr)];
      rd_hold <= 1'b1;
    end else if (rd_hold) begin
      rd_hold <= 1'b0;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end

  // access monitor; sees pre-update values at the edge
  always @(posedge clock) begin
    cyc++;
    if (!reset && mem_rd) begin
      rd_n++;
      rd_addr = mem_addr;
      rd_rs = mem_regspace;
      `CHK(mem_bank, flags[4], "bank")
    end
    if (!reset && mem_wr) begin
      wr_n++;
      wr_addr = mem_addr;
      wr_data = mem_wdata;
      wr_rs = mem_regspace;
      mem[slot(mem_regspace, mem_bank, mem_addr)] = mem_wdata;
    end
    // hang guard, far above the roughly 140 cycles needed
    if (cyc == 3000) begin
      num_errors++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one instruction: bytes sent whole, then wait for return to opcode state
  task automatic run(oam_pkg::oam_mode_e m, oam_pkg::oam_reg_e r, logic ar, logic mv,
                     logic an, logic rs, logic [7:0] b1, logic [7:0] b2);
    logic [7:0] b [3];
    int         n;
    int         k;
    bit         seen;
    n = (m == oam_pkg::OAM_MODE_NONE) ? 1 :
        (m inside {oam_pkg::OAM_MODE_DST_DIR_IMM, oam_pkg::OAM_MODE_DST_IDX_IMM,
                   oam_pkg::OAM_MODE_MEM_MEM}) ? 3 : 2;
    b[0] = 8'h00;
    b[1] = b1;
    b[2] = b2;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      byte_valid = 1'b1;
      byte_data = b[i];
      // class inputs go with the opcode byte and stay put
      if (i == 0) begin
        {mode, reg_sel, is_arith, is_move, is_and, to_regspace} = {m, r, ar, mv, an, rs};
      end
      k = 0;
      while (!byte_ready && k < 20) begin
        @(negedge clock);
        k++;
      end
      @(posedge clock);
    end
    @(negedge clock);
    byte_valid = 1'b0;
    seen = 0;
    // bounded wait: exec entered and left; refused modes pass through exec in one cycle with no access
    for (k = 0; k < 12 && !(seen && byte_ready); k++) begin
      if (!byte_ready) seen = 1;
      @(negedge clock);
    end
    // write strobe stands one cycle past exec; let the monitor record it
    @(negedge clock);
    `CHK(instr_len, 2'(n), "length")
  endtask

  task automatic t_reset();
    `CHK({acc, idx, stack_pointer}, 24'h000000, "regs at reset")
    `CHK(flags, 8'h02, "flags at reset")
    `CHK({mem_rd, mem_wr, byte_ready}, 3'h1, "strobes at reset")
    $display("done reset");
  endtask

  task automatic t_src_imm();
    // one-byte instruction first: length one, nothing else moves
    run(oam_pkg::OAM_MODE_NONE, oam_pkg::OAM_REG_ACC, 0, 0, 0, 0, 8'h00, 8'h00);
    run(oam_pkg::OAM_MODE_SRC_IMM, oam_pkg::OAM_REG_SP, 1, 0, 0, 0, 8'h05, 8'h00);
    `CHK(stack_pointer, 8'h05, "add sp imm")
    run(oam_pkg::OAM_MODE_SRC_IMM, oam_pkg::OAM_REG_ACC, 1, 0, 0, 0, 8'h07, 8'h00);
    `CHK(acc, 8'h07, "add imm")
    run(oam_pkg::OAM_MODE_SRC_IMM, oam_pkg::OAM_REG_IDX, 0, 1, 0, 0, 8'h08, 8'h00);
    `CHK(idx, 8'h08, "mov imm")
    run(oam_pkg::OAM_MODE_SRC_IMM, oam_pkg::OAM_REG_FLAGS, 0, 0, 1, 0, 8'h09, 8'h00);
    `CHK(flags, 8'h00, "and flags")
    $display("done source immediate");
  endtask

  task automatic t_src_dir();
    mem[10'h030] = 8'h15;
    mem[slot(1, 0, 8'h08)] = 8'h44;
    run(oam_pkg::OAM_MODE_SRC_DIR, oam_pkg::OAM_REG_ACC, 1, 0, 0, 0, 8'h30, 8'h00);
    `CHK(acc, 8'h1c, "add direct")
    `CHK({rd_addr, rd_rs}, {8'h30, 1'b0}, "direct addr")
    run(oam_pkg::OAM_MODE_SRC_DIR, oam_pkg::OAM_REG_IDX, 0, 1, 0, 1, 8'h08, 8'h00);
    `CHK(idx, 8'h44, "reg space read")
    `CHK(rd_rs, 1'b1, "reg space routed")
    run(oam_pkg::OAM_MODE_SRC_DIR, oam_pkg::OAM_REG_IDX, 1, 0, 0, 0, 8'h30, 8'h00);
    `CHK(idx, 8'h59, "second source idx")
    `CHK(acc, 8'h1c, "acc untouched")
    $display("done source direct");
  endtask

  task automatic t_src_idx();
    run(oam_pkg::OAM_MODE_SRC_IMM, oam_pkg::OAM_REG_IDX, 0, 1, 0, 0, 8'hf0, 8'h00);
    mem[10'h010] = 8'h03;
    // 0x20 + 0xf0 wraps to 0x10
    run(oam_pkg::OAM_MODE_SRC_IDX, oam_pkg::OAM_REG_ACC, 1, 0, 0, 0, 8'h20, 8'h00);
    `CHK(rd_addr, 8'h10, "indexed wrap")
    `CHK(acc, 8'h1f, "indexed add")
    $display("done source indexed");
  endtask

  task automatic t_dst();
    int n;
    mem[10'h040] = 8'h10;
    run(oam_pkg::OAM_MODE_DST_DIR, oam_pkg::OAM_REG_ACC, 1, 0, 0, 0, 8'h40, 8'h00);
    `CHK({rd_addr, wr_addr, wr_data}, 24'h40402f, "dest direct")
    `CHK(acc, 8'h1f, "acc kept")
    mem[10'h045] = 8'h01;
    run(oam_pkg::OAM_MODE_DST_IDX, oam_pkg::OAM_REG_ACC, 1, 0, 0, 0, 8'h55, 8'h00);
    `CHK({rd_addr, wr_addr, wr_data}, 24'h454520, "dest indexed")
    `CHK(acc, 8'h1f, "acc kept")
    n = rd_n + wr_n;
    run(oam_pkg::OAM_MODE_DST_IDX, oam_pkg::OAM_REG_IDX, 1, 0, 0, 0, 8'h55, 8'h00);
    `CHK(illegal, 1'b1, "idx source refused")
    `CHK(rd_n + wr_n, n, "no access")
    $display("done destination");
  endtask

  task automatic t_dst_imm();
    int n;
    mem[10'h060] = 8'h07;
    run(oam_pkg::OAM_MODE_DST_DIR_IMM, oam_pkg::OAM_REG_ACC, 1, 0, 0, 0, 8'h60, 8'h05);
    `CHK({wr_addr, wr_data, wr_rs}, {16'h600c, 1'b0}, "direct imm")
    n = rd_n;
    run(oam_pkg::OAM_MODE_DST_IDX_IMM, oam_pkg::OAM_REG_ACC, 0, 1, 0, 1, 8'h18, 8'h06);
    `CHK({wr_addr, wr_data, wr_rs}, {16'h0806, 1'b1}, "indexed imm")
    `CHK(rd_n, n, "move reads nothing")
    $display("done destination immediate");
  endtask

  task automatic t_mem_mem();
    int n;
    mem[10'h008] = 8'h5a;
    // register space asked for, but both ends must stay in ram
    run(oam_pkg::OAM_MODE_MEM_MEM, oam_pkg::OAM_REG_ACC, 0, 1, 0, 1, 8'h07, 8'h08);
    `CHK({rd_addr, rd_rs, wr_rs}, {8'h08, 2'b00}, "ram only")
    `CHK({wr_addr, wr_data, illegal}, {16'h075a, 1'b0}, "move done")
    `CHK(acc, 8'h1f, "acc kept")
    n = rd_n + wr_n;
    run(oam_pkg::OAM_MODE_MEM_MEM, oam_pkg::OAM_REG_ACC, 1, 0, 0, 0, 8'h07, 8'h08);
    `CHK({illegal, 32'(rd_n + wr_n)}, {1'b1, 32'(n)}, "non-move refused")
    $display("done memory to memory");
  endtask

  // bank one of register space, picked by the flags bank bit
  task automatic t_bank();
    run(oam_pkg::OAM_MODE_SRC_IMM, oam_pkg::OAM_REG_FLAGS, 0, 1, 0, 0, 8'h10, 8'h00);
    `CHK(mem_bank, 1'b1, "bank one selected")
    mem[slot(1, 1, 8'h08)] = 8'h66;
    run(oam_pkg::OAM_MODE_SRC_DIR, oam_pkg::OAM_REG_IDX, 0, 1, 0, 1, 8'h08, 8'h00);
    `CHK({idx, rd_rs}, {8'h66, 1'b1}, "bank one read")
    $display("done bank select");
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {clock, byte_valid, byte_data, is_arith, is_move, is_and, to_regspace} = '0;
    {mem_rdata, rd_hold, rd_n, wr_n, cyc, num_errors, cmp_count} = '0;
    mode = oam_pkg::OAM_MODE_NONE;
    reg_sel = oam_pkg::OAM_REG_ACC;
    reset = 1'b1;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    t_reset();
    t_src_imm();
    t_src_dir();
    t_src_idx();
    t_dst();
    t_dst_imm();
    t_mem_mem();
    t_bank();
    tally_and_finish();
  end
endmodule
